// >>> hdl/cfh_host_port.sv
// Flash card host port: pin behaviour for memory, I/O and IDE modes.
// Assumes user logic owns configuration, task file and data storage,
// and holds rd_data_i valid for the space shown on rd_space_o.
// Behaviour
// - I/O read data driven only under read strobe
// - I/O write data caught on strobe rising edge
// - IDE strobes act as I/O outside bursts
// - Host ready negated pauses read bursts
// - One word per data strobe edge
// - Stop during burst ends the burst
// - Output enable reads memory, or only attribute
// - Ready high when idle, low when busy
// - Ready low until reset processing ends
// - Reset pin held from power-up ignored
// - I/O interrupt low, pulsed or level
// - IDE interrupt is active high
// - Select high common, low attribute
// - Request held until acknowledge; reasserted if more
// - Acknowledge ignored when no transfer active
`timescale 1ns/1ps
`default_nettype none
`include "cfh_map.svh"
module cfh_host_port #(
   parameter int INIT_CYCLES = `CFH_INIT_CYCLES,
   parameter int IRQ_PULSE_CYCLES = `CFH_IRQ_PULSE_CYCLES,
   parameter int DW = `CFH_DATA_W
) (
   // Clocks and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic link_clk_i,
   // Host strobes and selects
   input wire logic io_read_strobe_n_i,
   input wire logic io_write_strobe_n_i,
   input wire logic output_enable_n_i,
   input wire logic attr_select_n_i,
   input wire logic ide_mode_select_n_i,
   input wire logic dma_acknowledge_n_i,
   input wire logic host_udma_ready_n_i,
   input wire logic host_data_strobe_i,
   input wire logic burst_stop_i,
   input wire logic card_reset_pin_i,
   // Data bus
   input wire logic [DW-1:0] data_i,
   output logic [DW-1:0] data_o,
   output logic data_oe_o,
   // Card outputs to host
   output logic ready_o,
   output logic io_interrupt_req_n_o,
   output logic ide_interrupt_o,
   output logic dma_request_o,
   // User control
   input wire logic io_mode_i,
   input wire logic udma_active_i,
   input wire logic udma_write_i,
   input wire logic busy_i,
   input wire logic irq_i,
   input wire logic irq_pulse_mode_i,
   input wire logic dma_want_i,
   input wire logic [DW-1:0] rd_data_i,
   // User results
   output cfh_pkg::cfh_space_t rd_space_o,
   output logic wr_valid_o,
   output logic [DW-1:0] wr_data_o,
   output logic wr_udma_o,
   output logic udma_pause_o,
   output logic burst_end_o,
   output logic card_reset_o
);
   import cfh_pkg::*;

   //------------------------------------------------------------
   // Pin synchronisers
   //------------------------------------------------------------
   logic rd_n_s; // Read strobe
   logic oe_n_s; // Output enable
   logic reg_n_s; // Attribute select
   logic sel_n_s; // Mode select
   logic dma_acknowledge_n_n_s; // Acknowledge
   logic hrdy_n_s; // Host ready
   logic stop_s; // Burst stop
   logic rpin_s; // Reset pin
   logic tog_s; // Link word toggle, synced
   logic tog_d; // Toggle history
   logic link_tog; // Link toggle, raw
   logic [DW-1:0] link_word; // Word held by link side
   logic link_udma; // Word came from a burst

   cfh_sync #(.W(8), .INIT(`CFH_PIN_IDLE)) u_pins (
      .clk_i(clock_i),
      .rstn_i(rstn_i),
      .d_i({card_reset_pin_i, burst_stop_i, host_udma_ready_n_i,
            dma_acknowledge_n_i, ide_mode_select_n_i, attr_select_n_i,
            output_enable_n_i, io_read_strobe_n_i}),
      .q_o({rpin_s, stop_s, hrdy_n_s, dma_acknowledge_n_n_s, sel_n_s, reg_n_s,
            oe_n_s, rd_n_s})
   );

   // Write strobes in the link domain
   cfh_link_capture #(.DW(DW)) u_link (
      .link_clk_i(link_clk_i),
      .rstn_i(rstn_i),
      .io_write_strobe_n_i(io_write_strobe_n_i),
      .host_data_strobe_i(host_data_strobe_i),
      .data_i(data_i),
      .udma_active_i(udma_active_i),
      .udma_write_i(udma_write_i),
      .word_o(link_word),
      .word_udma_o(link_udma),
      .toggle_o(link_tog)
   );

   // Toggle crossing
   cfh_sync #(.W(1)) u_tog (
      .clk_i(clock_i),
      .rstn_i(rstn_i),
      .d_i(link_tog),
      .q_o(tog_s)
   );

   //------------------------------------------------------------
   // Reset and ready
   //------------------------------------------------------------
   logic [15:0] init_cnt; // Cycles of reset work left
   logic init_busy; // Reset work running
   logic armed; // Reset pin seen negated once
   logic ide_mode; // Caught mode strap
   logic rst_asserted; // Reset pin in its active sense

   assign init_busy = (init_cnt != 16'h0000);
   // Pin is active high in card modes, active low in IDE
   assign rst_asserted = ide_mode ? !rpin_s : rpin_s;

   // Arm reset pin only after a negated sample
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         armed <= 1'b0;
      end else if (!rst_asserted && !init_busy) begin
         armed <= 1'b1;
      end
   end

   // Reset work counter
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         init_cnt <= 16'(INIT_CYCLES);
      // Held pin from power-up never reloads
      end else if (armed && rst_asserted) begin
         init_cnt <= 16'(INIT_CYCLES);
      end else if (init_busy) begin
         init_cnt <= init_cnt - 16'h0001;
      end
   end

   // Mode strap follows pin during reset work, then freezes
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ide_mode <= 1'b0;
      end else if (init_busy) begin
         ide_mode <= !sel_n_s;
      end
   end

   // Ready and card reset outputs
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ready_o <= 1'b0;
         card_reset_o <= 1'b1;
      end else begin
         // Busy through reset work, then user busy
         ready_o <= !init_busy && !busy_i;
         card_reset_o <= init_busy;
      end
   end

   //------------------------------------------------------------
   // Read drive
   //------------------------------------------------------------
   cfh_space_t next_space; // Target of this cycle
   logic io_space; // I/O strobes are live
   logic udma_on; // Burst protocol active in IDE

   assign udma_on = ide_mode && udma_active_i;
   // IDE outside bursts behaves as I/O mode
   assign io_space = (io_mode_i || ide_mode) && !udma_on;

   // Pick target from strobes
   always_comb begin
      next_space = CFH_SP_NONE;
      if (io_space && !rd_n_s) begin
         next_space = CFH_SP_IO;
      end else if (!ide_mode && !oe_n_s) begin
         if (io_mode_i) begin
            // Attribute only in I/O mode
            next_space = CFH_SP_ATTR;
         end else if (reg_n_s) begin
            next_space = CFH_SP_COMMON;
         end else begin
            next_space = CFH_SP_ATTR;
         end
      end
   end

   // Bus drive registers
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_space_o <= CFH_SP_NONE;
         data_oe_o <= 1'b0;
         data_o <= '0;
      end else begin
         rd_space_o <= next_space;
         data_oe_o <= (next_space != CFH_SP_NONE);
         data_o <= rd_data_i;
      end
   end

   //------------------------------------------------------------
   // Written words and bursts
   //------------------------------------------------------------
   logic tog_edge; // New word from link side
   logic burst_open; // Burst not yet stopped
   logic stop_d; // Stop history
   logic udma_d; // Burst active history

   assign tog_edge = tog_s ^ tog_d;

   // Toggle and level history
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tog_d <= 1'b0;
         stop_d <= 1'b0;
         udma_d <= 1'b0;
      end else begin
         tog_d <= tog_s;
         stop_d <= stop_s;
         udma_d <= udma_on;
      end
   end

   // Burst open from start until stop
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         burst_open <= 1'b0;
      end else if (udma_on && stop_s && !stop_d) begin
         burst_open <= 1'b0;
      end else if (udma_on && !udma_d) begin
         burst_open <= 1'b1;
      end else if (!udma_on) begin
         burst_open <= 1'b0;
      end
   end

   // Hand words to user logic
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_valid_o <= 1'b0;
         wr_data_o <= '0;
         wr_udma_o <= 1'b0;
      end else begin
         // I/O words always, burst words while open
         wr_valid_o <= tog_edge && (!link_udma || burst_open);
         if (tog_edge) begin
            wr_data_o <= link_word;
            wr_udma_o <= link_udma;
         end
      end
   end

   // Pause and stop reports
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         udma_pause_o <= 1'b0;
         burst_end_o <= 1'b0;
      end else begin
         // Host ready negated pauses read burst
         udma_pause_o <= udma_on && !udma_write_i && hrdy_n_s;
         burst_end_o <= udma_on && burst_open && stop_s && !stop_d;
      end
   end

   //------------------------------------------------------------
   // DMA request handshake
   //------------------------------------------------------------
   cfh_dma_t dma_state; // Handshake state
   cfh_dma_t next_dma; // Next handshake state

   // Next state
   always_comb begin
      next_dma = dma_state;
      unique case (dma_state)
         CFH_DMA_IDLE: begin
            if (ide_mode && dma_want_i) begin
               next_dma = CFH_DMA_REQ;
            end
         end
         CFH_DMA_REQ: begin
            if (!dma_acknowledge_n_n_s) begin
               next_dma = CFH_DMA_ACK;
            end
         end
         CFH_DMA_ACK: begin
            if (dma_acknowledge_n_n_s) begin
               next_dma = (ide_mode && dma_want_i) ? CFH_DMA_REQ : CFH_DMA_IDLE;
            end
         end
         default: next_dma = CFH_DMA_IDLE;
      endcase
   end

   // State and request pin
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dma_state <= CFH_DMA_IDLE;
         dma_request_o <= 1'b0;
      end else begin
         dma_state <= next_dma;
         dma_request_o <= (next_dma == CFH_DMA_REQ);
      end
   end

   //------------------------------------------------------------
   // Interrupts
   //------------------------------------------------------------
   logic [7:0] pulse_cnt; // Pulse cycles left
   logic irq_d; // Interrupt history
   logic io_cfg; // I/O interface configured

   assign io_cfg = io_mode_i && !ide_mode;

   // Pulse timer
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_d <= 1'b0;
         pulse_cnt <= 8'h00;
      end else begin
         irq_d <= irq_i;
         if (irq_i && !irq_d) begin
            pulse_cnt <= 8'(IRQ_PULSE_CYCLES);
         end else if (pulse_cnt != 8'h00) begin
            pulse_cnt <= pulse_cnt - 8'h01;
         end
      end
   end

   // Interrupt pins
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         io_interrupt_req_n_o <= 1'b1;
         ide_interrupt_o <= 1'b0;
      end else begin
         io_interrupt_req_n_o <= !(io_cfg && (irq_pulse_mode_i ?
                                 (pulse_cnt != 8'h00) : irq_i));
         ide_interrupt_o <= ide_mode && irq_i;
      end
   end

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   default clocking cb_c @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   property p_no_drive;
      (rd_n_s && oe_n_s) |=> !data_oe_o;
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("bus driven idle");

   property p_io_word;
      (tog_edge && !link_udma) |=> (wr_valid_o && wr_data_o == $past(link_word));
   endproperty
   a_io_word: assert property (p_io_word) else $error("write word lost");

   property p_udma_quiet;
      (udma_on && oe_n_s) |=> !data_oe_o;
   endproperty
   a_udma_quiet: assert property (p_udma_quiet) else $error("drive in burst");

   property p_pause;
      (udma_on && !udma_write_i && hrdy_n_s) |=> udma_pause_o;
   endproperty
   a_pause: assert property (p_pause) else $error("pause missed");

   property p_stop;
      (udma_on && burst_open && $rose(stop_s)) |=> (burst_end_o ##1 !burst_end_o);
   endproperty
   a_stop: assert property (p_stop) else $error("stop not seen");

   property p_attr;
      (!ide_mode && !io_mode_i && rd_n_s && !oe_n_s && !reg_n_s)
         |=> (rd_space_o == CFH_SP_ATTR);
   endproperty
   a_attr: assert property (p_attr) else $error("wrong space");

   property p_init_busy;
      init_busy |=> !ready_o;
   endproperty
   a_init_busy: assert property (p_init_busy) else $error("ready early");

   property p_held_pin;
      (!armed && !init_busy) |=> !init_busy;
   endproperty
   a_held_pin: assert property (p_held_pin) else $error("held reset acted");

   property p_ide_irq;
      ##1 (ide_interrupt_o == $past(ide_mode && irq_i));
   endproperty
   a_ide_irq: assert property (p_ide_irq) else $error("ide irq wrong");

   property p_req_hold;
      (dma_request_o && dma_acknowledge_n_n_s && !(dma_state == CFH_DMA_ACK)) |=> dma_request_o;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped");

   property p_idle_ack;
      (dma_state == CFH_DMA_IDLE && !dma_want_i) |=> !dma_request_o;
   endproperty
   a_idle_ack: assert property (p_idle_ack) else $error("ack not ignored");

   property p_io_level;
      (io_cfg && !irq_pulse_mode_i && irq_i) |=> !io_interrupt_req_n_o;
   endproperty
   a_io_level: assert property (p_io_level) else $error("level irq missed");

   c_io_write: cover property (wr_valid_o && !wr_udma_o);
   c_burst_word: cover property (wr_valid_o && wr_udma_o);
   c_dma_cycle: cover property (dma_request_o ##[1:50] !dma_request_o);
   c_stop: cover property (burst_end_o);
endmodule // cfh_host_port
`default_nettype wire

// >>> hdl/cfh_map.svh
// Named constants for the flash card host port: codes, reset values, counts.
// Assumes inclusion by bare name from the hdl/ folder.
`ifndef CFH_MAP_SVH
`define CFH_MAP_SVH

// Read target codes
`define CFH_SP_NONE 2'h0
`define CFH_SP_COMMON 2'h1
`define CFH_SP_ATTR 2'h2
`define CFH_SP_IO 2'h3

// DMA handshake state codes, one-hot
`define CFH_DMA_IDLE 3'h1
`define CFH_DMA_REQ 3'h2
`define CFH_DMA_ACK 3'h4

// Reset value of the synchronised host pins
`define CFH_PIN_IDLE 8'h3f
// Reset value of the link-side pins: write strobe high
`define CFH_LINK_IDLE 18'h20000

// Default counts in core cycles
`define CFH_INIT_CYCLES 16
`define CFH_IRQ_PULSE_CYCLES 4

// Data bus width
`define CFH_DATA_W 16

`endif

// >>> hdl/cfh_pkg.sv
// Types shared by the flash card host port.
// Assumes cfh_map.svh sits beside it.
`include "cfh_map.svh"
package cfh_pkg;
   // Read target of the current host strobe
   typedef enum logic [1:0] {
      CFH_SP_NONE = `CFH_SP_NONE,
      CFH_SP_COMMON = `CFH_SP_COMMON,
      CFH_SP_ATTR = `CFH_SP_ATTR,
      CFH_SP_IO = `CFH_SP_IO
   } cfh_space_t;
   // Request and acknowledge handshake states
   typedef enum logic [2:0] {
      CFH_DMA_IDLE = `CFH_DMA_IDLE,
      CFH_DMA_REQ = `CFH_DMA_REQ,
      CFH_DMA_ACK = `CFH_DMA_ACK
   } cfh_dma_t;
endpackage

// >>> hdl/cfh_sync.sv
// Two-flop level synchroniser, any width.
// Assumes each bit is a level or is bundled with a qualifier.
`timescale 1ns/1ps
`default_nettype none
module cfh_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Asynchronous in, synchronous out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta; // First stage, read only by q_o

   // Two stages
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta <= INIT;
         q_o <= INIT;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule // cfh_sync
`default_nettype wire

// >>> hdl/cfh_link_capture.sv
// Link-clock side: samples the host write strobes and data, catches words.
// Assumes the link clock samples faster than the host strobes toggle,
// and words arrive no faster than one per link cycle.
`timescale 1ns/1ps
`default_nettype none
`include "cfh_map.svh"
module cfh_link_capture
   import cfh_pkg::*;
#(
   parameter int DW = `CFH_DATA_W
) (
   // Link clock and reset
   input wire logic link_clk_i,
   input wire logic rstn_i,
   // Host pins
   input wire logic io_write_strobe_n_i,
   input wire logic host_data_strobe_i,
   input wire logic [DW-1:0] data_i,
   // Core control levels
   input wire logic udma_active_i,
   input wire logic udma_write_i,
   // Word toward the core
   output logic [DW-1:0] word_o,
   output logic word_udma_o,
   output logic toggle_o
);
   logic io_write_strobe_n_n_s; // Synced write strobe
   logic hs_s; // Synced data strobe
   logic [DW-1:0] data_s; // Data, same delay as strobes
   logic io_write_strobe_n_n_d; // Previous write strobe
   logic hs_d; // Previous data strobe
   logic udma_l; // Synced burst active
   logic udmaw_l; // Synced write direction
   logic io_evt; // Write strobe trailing edge
   logic hs_evt; // Data strobe either edge

   // Pins, two flops with data kept aligned
   cfh_sync #(.W(DW + 2), .INIT(`CFH_LINK_IDLE)) u_pins (
      .clk_i(link_clk_i),
      .rstn_i(rstn_i),
      .d_i({io_write_strobe_n_i, host_data_strobe_i, data_i}),
      .q_o({io_write_strobe_n_n_s, hs_s, data_s})
   );
   // Core levels
   cfh_sync #(.W(2)) u_ctl (
      .clk_i(link_clk_i),
      .rstn_i(rstn_i),
      .d_i({udma_active_i, udma_write_i}),
      .q_o({udma_l, udmaw_l})
   );

   // Edge history
   always_ff @(posedge link_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         io_write_strobe_n_n_d <= 1'b1;
         hs_d <= 1'b0;
      end else begin
         io_write_strobe_n_n_d <= io_write_strobe_n_n_s;
         hs_d <= hs_s;
      end
   end

   // Low to high edge, host strobe negated during bursts
   assign io_evt = io_write_strobe_n_n_s && !io_write_strobe_n_n_d && !udma_l;
   // Both edges of data strobe; idle strobe moves nothing
   assign hs_evt = (hs_s != hs_d) && udma_l && udmaw_l;

   // Word catch and toggle event
   always_ff @(posedge link_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         word_o <= '0;
         word_udma_o <= 1'b0;
         toggle_o <= 1'b0;
      end else if (io_evt || hs_evt) begin
         word_o <= data_s;
         word_udma_o <= hs_evt;
         toggle_o <= !toggle_o;
      end
   end

   default clocking cb_l @(posedge link_clk_i); endclocking
   default disable iff (!rstn_i);

   // Every data strobe edge in a write burst sends one word
   property p_hs_word;
      (udma_l && udmaw_l && $changed(hs_s)) |=> ($changed(toggle_o) && word_udma_o);
   endproperty
   a_hs_word: assert property (p_hs_word) else $error("strobe edge lost");
endmodule // cfh_link_capture
`default_nettype wire

// >>> verif/cfh_host_model.sv
// Host model: drives the write strobe, burst data strobe and data bus.
// Assumes the card samples these pins on the link clock.
`timescale 1ns/1ps
`default_nettype none
module cfh_host_model (
   // Link clock for pacing
   input wire logic link_clk_i,
   // Host pins toward the card
   output logic io_write_strobe_n_o,
   output logic host_data_strobe_o,
   output logic [15:0] data_o
);
   // Idle pins; strobe stays negated outside writes
   // write strobe idle high
   initial begin
      io_write_strobe_n_o = 1'b1;
      host_data_strobe_o = 1'b0;
      data_o = 16'h0000;
   end
   task automatic io_write(input logic [15:0] d, input int gap);
      @(negedge link_clk_i) data_o = d;
      repeat (3) @(negedge link_clk_i);
      io_write_strobe_n_o = 1'b0;
      repeat (3 + gap) @(negedge link_clk_i);
      io_write_strobe_n_o = 1'b1;
      repeat (3) @(negedge link_clk_i);
      data_o = ~d;
   endtask
   // one toggle per word, idle gap pauses
   task automatic burst_word(input logic [15:0] d, input int gap);
      repeat (1 + gap) @(negedge link_clk_i);
      data_o = d;
      repeat (3) @(negedge link_clk_i);
      host_data_strobe_o = ~host_data_strobe_o;
      repeat (3) @(negedge link_clk_i);
      data_o = ~d;
   endtask
endmodule // cfh_host_model
`default_nettype wire

// >>> verif/cfh_host_port_test.sv
// Testbench for the host port: host model, queue-checked words, pin checks.
// Assumes cfh_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cfh_host_port_test;
   import cfh_pkg::*;
   logic clock_i = 1'b0, link_clk_i = 1'b0, rstn_i = 1'b0;
   logic io_read_strobe_n_i = 1'b1, io_write_strobe_n_i, output_enable_n_i = 1'b1;
   logic attr_select_n_i = 1'b1, ide_mode_select_n_i = 1'b1, dma_acknowledge_n_i = 1'b1;
   logic host_udma_ready_n_i = 1'b0, host_data_strobe_i, burst_stop_i = 1'b0;
   logic card_reset_pin_i = 1'b1, io_mode_i = 1'b0, udma_active_i = 1'b0;
   logic udma_write_i = 1'b0, busy_i = 1'b0, irq_i = 1'b0, irq_pulse_mode_i = 1'b0;
   logic dma_want_i = 1'b0;
   logic [15:0] data_i, data_o, rd_data_i = 16'h0000, wr_data_o, d;
   logic data_oe_o, ready_o, io_interrupt_req_n_o, ide_interrupt_o, dma_request_o;
   logic wr_valid_o, wr_udma_o, udma_pause_o, burst_end_o, card_reset_o;
   cfh_space_t rd_space_o;
   logic [16:0] exp_q[$];
   int fails = 0, compares = 0, seed = 80928;
   cfh_host_port #(.INIT_CYCLES(16), .IRQ_PULSE_CYCLES(4), .DW(16)) cfh_host_port_inst (
      .clock_i, .rstn_i, .link_clk_i, .io_read_strobe_n_i, .io_write_strobe_n_i,
      .output_enable_n_i, .attr_select_n_i, .ide_mode_select_n_i, .dma_acknowledge_n_i,
      .host_udma_ready_n_i, .host_data_strobe_i, .burst_stop_i, .card_reset_pin_i,
      .data_i, .data_o, .data_oe_o, .ready_o, .io_interrupt_req_n_o, .ide_interrupt_o,
      .dma_request_o, .io_mode_i, .udma_active_i, .udma_write_i, .busy_i, .irq_i,
      .irq_pulse_mode_i, .dma_want_i, .rd_data_i, .rd_space_o, .wr_valid_o, .wr_data_o,
      .wr_udma_o, .udma_pause_o, .burst_end_o, .card_reset_o);
   cfh_host_model cfh_host_model_inst (.link_clk_i(link_clk_i),
      .io_write_strobe_n_o(io_write_strobe_n_i), .host_data_strobe_o(host_data_strobe_i),
      .data_o(data_i));
   // Core and link clocks, unrelated phase
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   initial begin
      #3;
      forever #40 link_clk_i = ~link_clk_i;
   end
   task automatic print_verdict();
      if (fails == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [16:0] seen, input logic [16:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic sig(input int w);
      case (w)
         0: return ready_o;
         1: return data_oe_o;
         2: return dma_request_o;
         3: return burst_end_o;
         default: return io_interrupt_req_n_o;
      endcase
   endfunction
   // Bounded wait for an output level
   task automatic wait_for(input int w, input logic v);
      int n;
      n = 0;
      while (sig(w) !== v && n < 100) begin
         @(negedge clock_i);
         n++;
      end
      check($sformatf("wait%0d", w), {16'h0000, sig(w)}, {16'h0000, v});
      if (n >= 100) print_verdict();
   endtask
   task automatic do_reset(input logic ide_n);
      rstn_i = 1'b0;
      ide_mode_select_n_i = ide_n;
      repeat (10) @(negedge clock_i);
      rstn_i = 1'b1;
   endtask
   // Word watcher: oldest note against each word
   always @(negedge clock_i) begin
      if (wr_valid_o === 1'b1) begin
         if (exp_q.size() == 0) check("extra_word", {wr_udma_o, wr_data_o}, 17'h1ffff);
         else check("word", {wr_udma_o, wr_data_o}, exp_q.pop_front());
      end
   end
   initial begin
      do_reset(1'b1);
      repeat (10) @(negedge clock_i);
      check("ready_init", ready_o, 17'h0);
      check("card_reset", card_reset_o, 17'h1);
      wait_for(0, 1'b1);
      check("card_reset_end", card_reset_o, 17'h0);
      busy_i = 1'b1;
      repeat (3) @(negedge clock_i);
      check("ready_busy", ready_o, 17'h0);
      busy_i = 1'b0;
      io_read_strobe_n_i = 1'b0;
      repeat (5) @(negedge clock_i);
      check("rd_refused", data_oe_o, 17'h0);
      io_read_strobe_n_i = 1'b1;
      for (int i = 0; i < 3; i++) begin
         io_mode_i = (i == 0);
         attr_select_n_i = (i != 2);
         output_enable_n_i = 1'b0;
         repeat (5) @(negedge clock_i);
         check("oe_space", rd_space_o, (i == 1) ? CFH_SP_COMMON : CFH_SP_ATTR);
         output_enable_n_i = 1'b1;
         repeat (5) @(negedge clock_i);
      end
      io_mode_i = 1'b1;
      rd_data_i = 16'($random(seed));
      io_read_strobe_n_i = 1'b0;
      wait_for(1, 1'b1);
      check("rd_space", rd_space_o, CFH_SP_IO);
      check("rd_data", data_o, rd_data_i);
      io_read_strobe_n_i = 1'b1;
      wait_for(1, 1'b0);
      for (int i = 0; i < 3; i++) begin
         d = 16'($random(seed));
         exp_q.push_back({1'b0, d});
         cfh_host_model_inst.io_write(d, i);
      end
      irq_i = 1'b1;
      repeat (3) @(negedge clock_i);
      check("irq_level", io_interrupt_req_n_o, 17'h0);
      irq_i = 1'b0;
      irq_pulse_mode_i = 1'b1;
      repeat (3) @(negedge clock_i);
      irq_i = 1'b1;
      wait_for(4, 1'b0);
      repeat (6) @(negedge clock_i);
      check("irq_pulse_end", io_interrupt_req_n_o, 17'h1);
      io_mode_i = 1'b0;
      do_reset(1'b0);
      wait_for(0, 1'b1);
      check("ide_irq", ide_interrupt_o, 17'h1);
      check("ide_no_io_interrupt_req_n", io_interrupt_req_n_o, 17'h1);
      irq_i = 1'b0;
      udma_write_i = 1'b1;
      udma_active_i = 1'b1;
      repeat (10) @(negedge clock_i);
      for (int i = 0; i < 4; i++) begin
         d = 16'($random(seed));
         exp_q.push_back({1'b1, d});
         cfh_host_model_inst.burst_word(d, i);
      end
      burst_stop_i = 1'b1;
      wait_for(3, 1'b1);
      cfh_host_model_inst.burst_word(16'h5a5a, 0);
      repeat (40) @(negedge clock_i);
      check("words_left", 17'(exp_q.size()), 17'h0);
      burst_stop_i = 1'b0;
      udma_write_i = 1'b0;
      repeat (4) @(negedge clock_i);
      check("no_pause", udma_pause_o, 17'h0);
      host_udma_ready_n_i = 1'b1;
      repeat (4) @(negedge clock_i);
      check("pause", udma_pause_o, 17'h1);
      udma_active_i = 1'b0;
      host_udma_ready_n_i = 1'b0;
      io_read_strobe_n_i = 1'b0;
      wait_for(1, 1'b1);
      io_read_strobe_n_i = 1'b1;
      wait_for(1, 1'b0);
      dma_acknowledge_n_i = 1'b0;
      repeat (5) @(negedge clock_i);
      check("ack_idle", dma_request_o, 17'h0);
      dma_acknowledge_n_i = 1'b1;
      dma_want_i = 1'b1;
      wait_for(2, 1'b1);
      repeat (8) @(negedge clock_i);
      check("req_held", dma_request_o, 17'h1);
      dma_acknowledge_n_i = 1'b0;
      wait_for(2, 1'b0);
      dma_acknowledge_n_i = 1'b1;
      wait_for(2, 1'b1);
      dma_want_i = 1'b0;
      dma_acknowledge_n_i = 1'b0;
      wait_for(2, 1'b0);
      dma_acknowledge_n_i = 1'b1;
      repeat (5) @(negedge clock_i);
      check("req_done", dma_request_o, 17'h0);
      print_verdict();
   end
endmodule // cfh_host_port_test
`default_nettype wire
